// [shared/seq_map.vh]
// register offsets, field positions, reset values and codes of the sequencer
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH
// ************************************************
// register word addresses
// ************************************************
`define A_CTRL 8'h00
`define A_START_SPEED 8'h01
`define A_ACCEL 8'h02
`define A_WRAP_REV 8'h03
`define A_WRAP_RATIO 8'h04
`define A_WRAP_OFFSET 8'h05
`define A_STEPS_PER_REV 8'h06
`define A_NET_NUMBER 8'h07
`define A_DIRECT_MAP0 8'h08
`define A_DIRECT_MAP1 8'h09
`define A_REC_INDEX 8'h0A
`define A_REC_POS 8'h0B
`define A_REC_SPEED 8'h0C
`define A_REC_MODE 8'h0D
`define A_STATUS 8'h10
`define A_IRQ_STATUS 8'h11
`define A_IRQ_MASK 8'h12
`define A_CMD_POS 8'h13
`define A_TARGET 8'h14
`define A_SPEED_NOW 8'h15
`define A_ACTIVE_REC 8'h16
// ************************************************
// fields
// ************************************************
`define CTRL_WRAP_EN 0
`define CTRL_START_SEL 1
`define IRQ_DONE 0
`define IRQ_ERROR 1
`define IRQ_START 2
// ************************************************
// reset values
// ************************************************
`define RST_START_SPEED 32'h0000_0001
`define RST_ACCEL 32'h0000_0001
`define RST_WRAP_REV 32'h0000_0001
`define RST_WRAP_RATIO 32'h0000_0032
`define RST_STEPS_PER_REV 32'h0000_2710
`define RST_NET_NUMBER 32'hFFFF_FFFF
`define RST_DIRECT_MAP0 32'h0302_0100
`define RST_DIRECT_MAP1 32'h0706_0504
// ************************************************
// move types
// ************************************************
`define MODE_ABS 3'h0
`define MODE_INC_CMD 3'h1
`define MODE_INC_FB 3'h2
`define MODE_WRAP_ABS 3'h3
`define MODE_WRAP_NEAR 3'h4
`define MODE_WRAP_FWD 3'h5
`define MODE_WRAP_REV 3'h6
`endif

// [design/sync2.v]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter W = 1
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta;
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// [design/record_select.v]
// picks the record number from network, direct and binary sources
`timescale 1ns/1ps
module record_select (
    input wire [31:0] net_number_in,
    input wire [7:0] direct_record_inputs_in,
    input wire [63:0] direct_map_in,
    input wire [7:0] record_select_bits_in,
    output reg [7:0] record_out,
    output reg direct_hit_out
);
    integer i;
    reg [3:0] ones;
    always @* begin
        ones = 4'h0;
        record_out = record_select_bits_in;
        direct_hit_out = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            ones = ones + {3'h0, direct_record_inputs_in[i]};
        end
        if (net_number_in < 32'h0000_0100) begin
            record_out = net_number_in[7:0];
        end else if (ones == 4'h1) begin
            direct_hit_out = 1'b1;
            for (i = 0; i < 8; i = i + 1) begin
                if (direct_record_inputs_in[i]) begin
                    record_out = direct_map_in[i*8 +: 8];
                end
            end
        end
    end
endmodule

// [design/position_sequencer.v]
// stored record positioning sequencer with start and ready handshake
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "seq_map.vh"
// ************************************************
// ************************************************
module position_sequencer #(
    parameter RECORDS = 256
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire start_in,
    input wire [7:0] record_select_bits_in,
    input wire [7:0] direct_record_inputs_in,
    input wire [31:0] feedback_pos_in,
    output reg ready_out,
    output reg step_out,
    output reg dir_out,
    output reg alarm_out,
    output reg irq_out
);
    localparam S_IDLE = 2'd0;
    localparam S_PLAN = 2'd1;
    localparam S_MOVE = 2'd2;
    localparam S_DONE = 2'd3;

    // ************************************************
    // stored records and configuration
    // ************************************************
    reg [31:0] rec_pos [0:RECORDS-1];
    reg [31:0] rec_speed [0:RECORDS-1];
    reg [2:0] rec_mode [0:RECORDS-1];
    reg [1:0] ctrl;
    reg [31:0] start_speed, accel, wrap_rev, wrap_ratio, wrap_offset;
    reg [31:0] steps_per_rev, net_number, rec_index;
    reg [63:0] direct_map;
    reg [2:0] irq_status, irq_mask;
    reg [1:0] state;
    reg [7:0] active_rec;
    reg signed [31:0] cmd_pos, target;
    reg [31:0] remaining, speed_now, cruise, phase_acc;
    reg start_d;

    wire [7:0] sel_rec;
    wire direct_hit;
    wire [7:0] sel_bits_s, direct_s;
    wire [31:0] fb_s;
    wire start_s;

    sync2 #(.W(49)) u_sync (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .d_in({start_in, record_select_bits_in, direct_record_inputs_in,
               feedback_pos_in}),
        .q_out({start_s, sel_bits_s, direct_s, fb_s})
    );

    record_select u_sel (
        .net_number_in(net_number),
        .direct_record_inputs_in(direct_s),
        .direct_map_in(direct_map),
        .record_select_bits_in(sel_bits_s),
        .record_out(sel_rec),
        .direct_hit_out(direct_hit)
    );

    // direct inputs may start a move on their own when enabled
    wire start_edge = (start_s & ~start_d) |
        (ctrl[`CTRL_START_SEL] & direct_hit & ~start_d);
    wire [7:0] ri = rec_index[7:0];
    wire [31:0] r_pos = rec_pos[active_rec];
    wire [31:0] r_spd = rec_speed[active_rec];
    wire [2:0] r_mode = rec_mode[active_rec];

    // ************************************************
    // wrap geometry
    // ************************************************
    // span is revs times steps; the lower edge sits ratio percent below
    // the offset, so 50 percent centres the range on it
    wire [63:0] span_w = wrap_rev * steps_per_rev;
    wire [31:0] span = span_w[31:0];
    wire signed [31:0] low_pct = $signed(wrap_offset) -
        $signed(span / 32'd100 * wrap_ratio);

    function [31:0] wrap_mod;
        input [31:0] v;
        input [31:0] m;
        begin
            wrap_mod = (m == 32'h0) ? 32'h0 : v % m;
        end
    endfunction

    // positions inside the range, measured from its lower edge
    wire [31:0] cur_w = wrap_mod(cmd_pos - low_pct + span, span);
    wire [31:0] tgt_w = wrap_mod(r_pos - low_pct, span);
    wire [31:0] fwd_d = wrap_mod(tgt_w - cur_w + span, span);
    wire [31:0] rev_d = (fwd_d == 32'h0) ? 32'h0 : span - fwd_d;

    // ************************************************
    // move planning
    // ************************************************
    reg signed [32:0] next_delta;
    always @* begin
        next_delta = 33'h0;
        case (r_mode)
            `MODE_ABS: next_delta = $signed({r_pos[31], r_pos}) -
                $signed({cmd_pos[31], cmd_pos});
            `MODE_INC_CMD: next_delta = {r_pos[31], r_pos};
            `MODE_INC_FB: next_delta = $signed({r_pos[31], r_pos}) +
                $signed({fb_s[31], fb_s}) -
                $signed({cmd_pos[31], cmd_pos});
            `MODE_WRAP_ABS: next_delta = (tgt_w >= cur_w) ?
                {1'b0, tgt_w - cur_w} :
                -$signed({1'b0, cur_w - tgt_w});
            `MODE_WRAP_NEAR: next_delta = (fwd_d <= rev_d) ?
                {1'b0, fwd_d} : -$signed({1'b0, rev_d});
            `MODE_WRAP_FWD: next_delta = {1'b0, fwd_d};
            `MODE_WRAP_REV: next_delta = -$signed({1'b0, rev_d});
            default: next_delta = 33'h0;
        endcase
        if (r_mode >= `MODE_WRAP_ABS && !ctrl[`CTRL_WRAP_EN]) begin
            next_delta = {r_pos[31], r_pos};
        end
    end

    wire [31:0] spd_abs = r_spd[31] ? -r_spd : r_spd;
    // target past the signed 32-bit window cannot be reached
    wire signed [32:0] next_target = $signed({cmd_pos[31], cmd_pos}) +
        next_delta;
    wire range_err = (next_target[32] != next_target[31]) |
        (next_delta[32] != next_delta[31]);

    // ************************************************
    // sequencer and speed profile
    // ************************************************
    // step pulses are paced by a phase accumulator; speed is steps per
    // 2^32 clock ticks scaled, adequate for a simple profile generator
    wire [32:0] phase_sum = {1'b0, phase_acc} + {1'b0, speed_now};
    wire [31:0] brake_dist = (accel == 32'h0) ? 32'h0 :
        (speed_now - start_speed) / accel;
    integer k;
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= S_IDLE;
            ready_out <= 1'b1;
            step_out <= 1'b0;
            dir_out <= 1'b0;
            alarm_out <= 1'b0;
            start_d <= 1'b0;
            active_rec <= 8'h00;
            cmd_pos <= 32'h0;
            target <= 32'h0;
            remaining <= 32'h0;
            speed_now <= 32'h0;
            cruise <= 32'h0;
            phase_acc <= 32'h0;
            irq_status <= 3'h0;
            irq_out <= 1'b0;
        end else begin
            start_d <= start_s | (ctrl[`CTRL_START_SEL] & direct_hit);
            step_out <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_edge) begin
                        active_rec <= sel_rec;
                        ready_out <= 1'b0;
                        alarm_out <= 1'b0;
                        irq_status[`IRQ_START] <= 1'b1;
                        state <= S_PLAN;
                    end
                end
                S_PLAN: begin
                    if (range_err) begin
                        alarm_out <= 1'b1;
                        irq_status[`IRQ_ERROR] <= 1'b1;
                        state <= S_DONE;
                    end else begin
                        target <= next_target[31:0];
                        dir_out <= next_delta[32];
                        remaining <= next_delta[32] ? -next_delta[31:0] :
                            next_delta[31:0];
                        cruise <= (spd_abs < start_speed) ?
                            start_speed : spd_abs;
                        speed_now <= start_speed;
                        phase_acc <= 32'h0;
                        state <= S_MOVE;
                    end
                end
                S_MOVE: begin
                    if (remaining == 32'h0) begin
                        state <= S_DONE;
                    end else begin
                        phase_acc <= phase_sum[31:0];
                        if (phase_sum[32]) begin
                            step_out <= 1'b1;
                            remaining <= remaining - 32'h1;
                            cmd_pos <= dir_out ? cmd_pos - 32'sh1 :
                                cmd_pos + 32'sh1;
                            // decelerate once the brake run covers the rest
                            if (remaining <= brake_dist + 32'h1 &&
                                speed_now > start_speed + accel) begin
                                speed_now <= speed_now - accel;
                            end else if (speed_now + accel <= cruise &&
                                remaining > brake_dist + 32'h1) begin
                                speed_now <= speed_now + accel;
                            end else if (remaining > brake_dist + 32'h1) begin
                                speed_now <= cruise;
                            end
                        end
                    end
                end
                S_DONE: begin
                    speed_now <= 32'h0;
                    ready_out <= 1'b1;
                    irq_status[`IRQ_DONE] <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            // write-one clears; a new event in the same cycle wins
            if (wr_in && addr_in == `A_IRQ_STATUS) begin
                for (k = 0; k < 3; k = k + 1) begin
                    if (wdata_in[k] &&
                        !(k == `IRQ_START && state == S_IDLE && start_edge) &&
                        !(k == `IRQ_ERROR && state == S_PLAN && range_err) &&
                        !(k == `IRQ_DONE && state == S_DONE)) begin
                        irq_status[k] <= 1'b0;
                    end
                end
            end
            irq_out <= |(irq_status & irq_mask);
        end
    end

    // ************************************************
    // register port
    // ************************************************
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl <= 2'h0;
            start_speed <= `RST_START_SPEED;
            accel <= `RST_ACCEL;
            wrap_rev <= `RST_WRAP_REV;
            wrap_ratio <= `RST_WRAP_RATIO;
            wrap_offset <= 32'h0;
            steps_per_rev <= `RST_STEPS_PER_REV;
            net_number <= `RST_NET_NUMBER;
            direct_map <= {`RST_DIRECT_MAP1, `RST_DIRECT_MAP0};
            rec_index <= 32'h0;
            irq_mask <= 3'h0;
        end else if (wr_in) begin
            case (addr_in)
                `A_CTRL: ctrl <= wdata_in[1:0];
                `A_START_SPEED: start_speed <= wdata_in;
                `A_ACCEL: accel <= wdata_in;
                `A_WRAP_REV: wrap_rev <= wdata_in;
                `A_WRAP_RATIO: wrap_ratio <= wdata_in;
                `A_WRAP_OFFSET: wrap_offset <= wdata_in;
                `A_STEPS_PER_REV: steps_per_rev <= wdata_in;
                `A_NET_NUMBER: net_number <= wdata_in;
                `A_DIRECT_MAP0: direct_map[31:0] <= wdata_in;
                `A_DIRECT_MAP1: direct_map[63:32] <= wdata_in;
                `A_REC_INDEX: rec_index <= {24'h0, wdata_in[7:0]};
                `A_IRQ_MASK: irq_mask <= wdata_in[2:0];
                default: ;
            endcase
        end
    end

    // record memory has no reset; software loads it before use
    always @(posedge mclk_in) begin
        if (wr_in && addr_in == `A_REC_POS) rec_pos[ri] <= wdata_in;
        if (wr_in && addr_in == `A_REC_SPEED) rec_speed[ri] <= wdata_in;
        if (wr_in && addr_in == `A_REC_MODE) rec_mode[ri] <= wdata_in[2:0];
    end

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h0;
        end else if (rd_in) begin
            case (addr_in)
                `A_CTRL: rdata_out <= {30'h0, ctrl};
                `A_START_SPEED: rdata_out <= start_speed;
                `A_ACCEL: rdata_out <= accel;
                `A_WRAP_REV: rdata_out <= wrap_rev;
                `A_WRAP_RATIO: rdata_out <= wrap_ratio;
                `A_WRAP_OFFSET: rdata_out <= wrap_offset;
                `A_STEPS_PER_REV: rdata_out <= steps_per_rev;
                `A_NET_NUMBER: rdata_out <= net_number;
                `A_DIRECT_MAP0: rdata_out <= direct_map[31:0];
                `A_DIRECT_MAP1: rdata_out <= direct_map[63:32];
                `A_REC_INDEX: rdata_out <= rec_index;
                `A_REC_POS: rdata_out <= rec_pos[ri];
                `A_REC_SPEED: rdata_out <= rec_speed[ri];
                `A_REC_MODE: rdata_out <= {29'h0, rec_mode[ri]};
                `A_STATUS: rdata_out <= {28'h0, alarm_out, ready_out, state};
                `A_IRQ_STATUS: rdata_out <= {29'h0, irq_status};
                `A_IRQ_MASK: rdata_out <= {29'h0, irq_mask};
                `A_CMD_POS: rdata_out <= cmd_pos;
                `A_TARGET: rdata_out <= target;
                `A_SPEED_NOW: rdata_out <= speed_now;
                `A_ACTIVE_REC: rdata_out <= {24'h0, active_rec};
                default: rdata_out <= 32'h0;
            endcase
        end else begin
            rdata_out <= 32'h0;
        end
    end
endmodule

// [sim/sequencer_checker.sv]
// port assertions for the stored record positioning sequencer
`timescale 1ns/1ps
module sequencer_checker #(
    parameter RECORDS = 256
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire start_in,
    input wire [7:0] record_select_bits_in,
    input wire [7:0] direct_record_inputs_in,
    input wire [31:0] feedback_pos_in,
    input wire ready_out,
    input wire step_out,
    input wire dir_out,
    input wire alarm_out,
    input wire irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // start passes two sync flops, so ready may lag the pin by a few edges
    property p_start_drops_ready;
        ready_out && $rose(start_in) |-> ##[1:5] !ready_out;
    endproperty
    a_start_drops_ready: assert property (p_start_drops_ready)
        else $error("ready stayed high after start");
    property p_ready_low_span;
        $fell(ready_out) |-> !ready_out [*2];
    endproperty
    a_ready_low_span: assert property (p_ready_low_span)
        else $error("ready came back too soon");
    property p_ready_returns;
        $fell(ready_out) |-> ##[1:1000] ready_out;
    endproperty
    a_ready_returns: assert property (p_ready_returns)
        else $error("ready never came back");
    property p_idle_no_step;
        ready_out |-> !step_out;
    endproperty
    a_idle_no_step: assert property (p_idle_no_step)
        else $error("step while ready");
    property p_alarm_no_step;
        alarm_out |-> !step_out;
    endproperty
    a_alarm_no_step: assert property (p_alarm_no_step)
        else $error("step while alarm");
    property p_alarm_clear;
        $fell(alarm_out) |-> !ready_out;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm cleared outside a start");
    property p_dir_steady;
        step_out |-> $stable(dir_out);
    endproperty
    a_dir_steady: assert property (p_dir_steady)
        else $error("direction moved at a step");
    property p_rdata_idle;
        !$past(rd_in) |-> rdata_out == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read cycle");
endmodule
bind position_sequencer sequencer_checker #(.RECORDS(RECORDS)) i_chk (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .start_in(start_in),
    .record_select_bits_in(record_select_bits_in),
    .direct_record_inputs_in(direct_record_inputs_in),
    .feedback_pos_in(feedback_pos_in), .ready_out(ready_out),
    .step_out(step_out), .dir_out(dir_out), .alarm_out(alarm_out),
    .irq_out(irq_out));

// [sim/host_ctrl.sv]
// host controller model driving select bits and the start handshake
`timescale 1ns/1ps
module host_ctrl (
    input wire mclk_in,
    input wire ready_in,
    output logic start_out,
    output logic [7:0] sel_out
);
    initial begin
        start_out = 1'b0;
        sel_out = 8'h00;
    end
    // lag stretches select setup to play a slow host
    task automatic run(input logic [7:0] rec, input int lag);
        int n;
        n = 0;
        while (ready_in !== 1'b1 && n < 4000) begin
            @(posedge mclk_in);
            n++;
        end
        sel_out <= rec;
        repeat (3 + lag) @(posedge mclk_in);
        start_out <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (ready_in !== 1'b0 && n < 20);
        start_out <= 1'b0;
        // select is scrambled so a device that re-reads it goes wrong
        sel_out <= ~rec;
        n = 0;
        while (ready_in !== 1'b1 && n < 4000) begin
            @(posedge mclk_in);
            n++;
        end
    endtask
endmodule

// [sim/tb_positioning_command_sequencer.sv]
// self-checking testbench of the positioning command sequencer
`timescale 1ns/1ps
`include "seq_map.vh"
module tb_positioning_command_sequencer;
    logic mclk_in, nrst_in, wr_in, rd_in, start, ready_out, step_out;
    logic dir_out, alarm_out, irq_out;
    logic [7:0] addr_in, sel, direct_in;
    logic [31:0] wdata_in, rdata_out, fb_pos;
    int fails = 0;
    int checked = 0;
    int steps = 0;
    int revs = 0;
    int cycles = 0;

    position_sequencer i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .start_in(start),
        .record_select_bits_in(sel), .direct_record_inputs_in(direct_in),
        .feedback_pos_in(fb_pos), .ready_out(ready_out),
        .step_out(step_out), .dir_out(dir_out), .alarm_out(alarm_out),
        .irq_out(irq_out));
    host_ctrl i_host (.mclk_in(mclk_in), .ready_in(ready_out),
        .start_out(start), .sel_out(sel));

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // ************************************************
    // step monitor and hang guard
    // ************************************************
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (step_out === 1'b1) begin
            steps <= steps + 1;
            revs <= revs + ((dir_out === 1'b1) ? 1 : 0);
        end
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(posedge mclk_in);
        chk(what, exp, rdata_out);
    endtask
    task automatic load(input logic [7:0] idx, input logic [31:0] pos,
                        input logic [31:0] spd, input logic [2:0] mode);
        wr(`A_REC_INDEX, {24'h0000_00, idx});
        wr(`A_REC_POS, pos);
        wr(`A_REC_SPEED, spd);
        wr(`A_REC_MODE, {29'h0000_0000, mode});
    endtask
    // counts steps of one move and how many of them ran in reverse
    task automatic mv(input logic [7:0] rec, input int n, input int nrev,
                      input int lag);
        int s0, r0;
        s0 = steps;
        r0 = revs;
        i_host.run(rec, lag);
        chk("steps", n, steps - s0);
        chk("reverse steps", nrev, revs - r0);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset();
        chk("ready", 32'h1, {31'h0, ready_out});
        rdchk(`A_START_SPEED, `RST_START_SPEED, "start speed");
        rdchk(`A_NET_NUMBER, `RST_NET_NUMBER, "net number");
        rdchk(`A_DIRECT_MAP0, `RST_DIRECT_MAP0, "direct map");
        wr(8'h31, 32'h1234_5678);
        rdchk(8'h31, 32'h0000_0000, "unmapped");
        $display("done reset");
    endtask
    task automatic t_moves();
        wr(`A_START_SPEED, 32'h2000_0000);
        wr(`A_ACCEL, 32'h0800_0000);
        load(8'hA5, 32'h0000_0014, 32'h4000_0000, `MODE_ABS);
        mv(8'hA5, 20, 0, 0);
        rdchk(`A_CMD_POS, 32'h0000_0014, "cmd pos");
        rdchk(`A_ACTIVE_REC, 32'h0000_00A5, "active rec");
        load(8'hFF, 32'hFFFF_FFFB, 32'hC000_0000, `MODE_INC_CMD);
        mv(8'hFF, 5, 5, 0);
        rdchk(`A_CMD_POS, 32'h0000_000F, "cmd pos");
        load(8'h00, 32'hFFFF_FFA6, 32'h4000_0000, `MODE_INC_FB);
        mv(8'h00, 5, 5, 0);
        rdchk(`A_TARGET, 32'h0000_000A, "target");
        $display("done moves");
    endtask
    task automatic t_error();
        wr(`A_IRQ_MASK, 32'h0000_0002);
        load(8'h03, 32'h7FFF_FFFF, 32'h4000_0000, `MODE_INC_CMD);
        mv(8'h03, 0, 0, 0);
        chk("alarm", 32'h1, {31'h0, alarm_out});
        chk("irq", 32'h1, {31'h0, irq_out});
        rdchk(`A_IRQ_STATUS, 32'h0000_0007, "irq status");
        wr(`A_IRQ_STATUS, 32'h0000_0002);
        rdchk(`A_IRQ_STATUS, 32'h0000_0005, "irq status cleared");
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        $display("done error");
    endtask
    task automatic t_prio();
        int s0;
        direct_in <= 8'h04;
        load(8'h02, 32'h0000_000C, 32'h4000_0000, `MODE_ABS);
        mv(8'h05, 2, 0, 4);
        chk("alarm", 32'h0, {31'h0, alarm_out});
        rdchk(`A_ACTIVE_REC, 32'h0000_0002, "active rec");
        wr(`A_NET_NUMBER, 32'h0000_0007);
        load(8'h07, 32'h0000_000A, 32'h4000_0000, `MODE_ABS);
        mv(8'h05, 2, 2, 0);
        rdchk(`A_ACTIVE_REC, 32'h0000_0007, "active rec");
        wr(`A_NET_NUMBER, 32'hFFFF_FFFF);
        // the held direct input alone starts record 2 once enabled
        s0 = steps;
        wr(`A_CTRL, 32'h0000_0002);
        repeat (40) @(posedge mclk_in);
        chk("direct start steps", 2, steps - s0);
        chk("ready", 32'h1, {31'h0, ready_out});
        direct_in <= 8'h00;
        $display("done priority");
    endtask
    // range of one 100 step revolution centred on zero: -50 to 49
    task automatic t_wrap();
        wr(`A_STEPS_PER_REV, 32'h0000_0064);
        wr(`A_CTRL, 32'h0000_0001);
        load(8'h10, 32'h0000_0005, 32'h4000_0000, `MODE_WRAP_FWD);
        mv(8'h10, 93, 0, 0);
        load(8'h11, 32'hFFFF_FFD8, 32'h4000_0000, `MODE_WRAP_NEAR);
        mv(8'h11, 45, 45, 0);
        load(8'h12, 32'h0000_001E, 32'h4000_0000, `MODE_WRAP_ABS);
        mv(8'h12, 70, 0, 0);
        load(8'h13, 32'h0000_0014, 32'h4000_0000, `MODE_WRAP_REV);
        mv(8'h13, 10, 10, 0);
        rdchk(`A_CMD_POS, 32'h0000_0078, "cmd pos");
        $display("done wrap");
    endtask

    initial begin
        nrst_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0000_0000;
        direct_in = 8'h00;
        fb_pos = 32'h0000_0064;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_moves();
        t_error();
        t_prio();
        t_wrap();
        report_and_stop();
    end
endmodule
